// ---- inc/tmc_pkg.sv ----
/*
 * Package of the 8-bit counter/compare timer: register indices, field
 * layouts, reset values, waveform and output mode encodings, prescale taps.
 * Assumes a CPU port with index addressing and 8-bit data.
 */
package tmc_pkg;
    localparam int unsigned CNT_W = 8;

    // Register indices on the plain CPU port
    localparam logic [2:0] IDX_TIMER_CONTROL = 3'h0;
    localparam logic [2:0] IDX_COUNT_VALUE   = 3'h1;
    localparam logic [2:0] IDX_MATCH_VALUE   = 3'h2;
    localparam logic [2:0] IDX_IRQ_FLAG      = 3'h3;
    localparam logic [2:0] IDX_IRQ_MASK      = 3'h4;
    localparam logic [2:0] IDX_ASYNC_STATUS  = 3'h5;

    // timer_control_reg fields
    localparam int unsigned CTL_CS_LSB    = 0;
    localparam int unsigned CTL_WGM0_BIT  = 3;
    localparam int unsigned CTL_COM_LSB   = 4;
    localparam int unsigned CTL_WGM1_BIT  = 6;
    localparam int unsigned CTL_FORCE_BIT = 7;

    // Flag and mask bits, async select bit
    localparam int unsigned WRAP_BIT  = 0;
    localparam int unsigned MATCH_BIT = 1;
    localparam int unsigned ASYNC_SEL_BIT = 3;

    localparam logic [7:0] CTL_RESET   = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MATCH_RESET = 8'h00;

    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;

    typedef enum logic [1:0] {
        TMC_WGM_NORMAL = 2'h0,
        TMC_WGM_PCPWM  = 2'h1,
        TMC_WGM_CTC    = 2'h2,
        TMC_WGM_FAST   = 2'h3
    } tmc_wgm_t;

    typedef enum logic [1:0] {
        TMC_COM_OFF    = 2'h0,
        TMC_COM_TOGGLE = 2'h1,
        TMC_COM_CLEAR  = 2'h2,
        TMC_COM_SET    = 2'h3
    } tmc_com_t;

    // Prescaler taps: divide = 2**tap
    localparam int unsigned PRESCALE_W = 10;
    localparam logic [3:0] TAP_DIV8    = 4'h3;
    localparam logic [3:0] TAP_DIV32   = 4'h5;
    localparam logic [3:0] TAP_DIV64   = 4'h6;
    localparam logic [3:0] TAP_DIV128  = 4'h7;
    localparam logic [3:0] TAP_DIV256  = 4'h8;
    localparam logic [3:0] TAP_DIV1024 = 4'hA;
endpackage : tmc_pkg

// ---- inc/tmc_tick_if.sv ----
/*
 * Interface between the timer core and its tick generator.
 * Assumes both ends share mclk.
 */
`timescale 1ns/10ps
`default_nettype none
interface tmc_tick_if;
    logic [2:0] clockSelect;
    logic       asyncSelect;
    logic       crystalTick;
    logic       timerTick;
    modport gen  (input clockSelect, input asyncSelect, input crystalTick, output timerTick);
    modport core (output clockSelect, output asyncSelect, output crystalTick, input timerTick);
endinterface : tmc_tick_if
`default_nettype wire

// ---- rtl/tmc_tick_gen.sv ----
/*
 * Tick generator: prescaled io_clock or crystal edges, gated by the
 * clock select field. Assumes crystalTick is already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
module tmc_tick_gen
    import tmc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rstN,
    tmc_tick_if.gen   tick
);
    logic [PRESCALE_W-1:0] prescale_reg;
    logic                  timerTick_next;

    function automatic logic tapEdge(input logic [PRESCALE_W-1:0] cnt, input logic [3:0] tap);
        logic [PRESCALE_W-1:0] mask;
        mask = (PRESCALE_W'(1) << tap) - PRESCALE_W'(1);
        return (cnt & mask) == mask;
    endfunction : tapEdge

    // Free-running; shared by all divide taps
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + PRESCALE_W'(1);
        end
    end

    always_comb begin
        timerTick_next = 1'b0;
        unique case (tick.clockSelect)
            3'h0: timerTick_next = 1'b0;
            3'h1: timerTick_next = tick.asyncSelect ? tick.crystalTick : 1'b1;
            3'h2: timerTick_next = tapEdge(prescale_reg, TAP_DIV8);
            3'h3: timerTick_next = tapEdge(prescale_reg, TAP_DIV32);
            3'h4: timerTick_next = tapEdge(prescale_reg, TAP_DIV64);
            3'h5: timerTick_next = tapEdge(prescale_reg, TAP_DIV128);
            3'h6: timerTick_next = tapEdge(prescale_reg, TAP_DIV256);
            3'h7: timerTick_next = tapEdge(prescale_reg, TAP_DIV1024);
        endcase
    end

    assign tick.timerTick = timerTick_next;
endmodule : tmc_tick_gen
`default_nettype wire

// ---- rtl/timer8_counter_compare.sv ----
/*
 * 8-bit counter with one compare unit, four waveform modes, wrap and
 * match flags with masks, forced compare and compare-output state.
 * Assumes a single-cycle CPU port on mclk; crystal pin is asynchronous.
 */
// Added by the designer: strobed register access and the address map.
// Behaviour
// - Counter and compare register are both 8 bits wide.
// - Bottom indication is registered: high in the cycle after the counter is zero.
// - Maximum is reached when counter holds 0xFF.
// - Top is 0xFF or the compare value, chosen by waveform mode.
// - Tick from io_clock by default, from crystal when async select set and clock select is 1.
// - Clock select zero stops the counter completely.
// - CPU reads and writes counter with or without ticks.
// - CPU counter write beats clear, increment or decrement.
// - Each tick clears, increments or decrements per waveform mode.
// - Match sets the match flag one tick later.
// - Match interrupt request is registered: high in the cycle after flag and enable are both set.
// - Match flag clears on service or on writing one.
// - PWM modes double-buffer compare value, updated at top in both modes.
// - CPU compare accesses go to buffer when buffering active.
// - Force strobe updates output only in non-PWM modes, no flag or clear.
// - Counter write blocks compare match on the next tick.
// - Output state kept across waveform mode changes.
// - Output mode changes act immediately, not buffered.
// - Wrap flag set per waveform mode, usable as interrupt.
// - All flags in one register, each gated by a mask bit.
// - Normal mode counts up, wraps 0xFF to 0, flags wrap on reaching 0.
// - Clear-on-match mode clears counter on match; compare value is top.
// - Output mode zero leaves output state alone on match.
`timescale 1ns/10ps
`default_nettype none
module timer8_counter_compare
    import tmc_pkg::*;
#(
    parameter int unsigned ADDR_W = 3
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [7:0]        busWdata,
    input  wire logic              busWrite,
    input  wire logic              busRead,
    output logic      [7:0]        busRdata,
    input  wire logic              crystalPinOne,
    input  wire logic              matchIrqAck,
    input  wire logic              wrapIrqAck,
    output logic                   matchIrq,
    output logic                   wrapIrq,
    output logic                   matchOutput,
    output logic                   bottomFlag
);
    import tmc_pkg::*;

    logic [1:0]       rstSync_reg;
    logic             rstN;
    logic [2:0]       xtalSync_reg;
    logic [2:0]       clockSelect_reg;
    tmc_wgm_t         wgm_reg;
    tmc_com_t         com_reg;
    logic             asyncSel_reg;
    logic [CNT_W-1:0] countValue_reg;
    logic [CNT_W-1:0] matchValue_reg;
    logic [CNT_W-1:0] matchBuf_reg;
    logic             dirDown_reg;
    logic             block_reg;
    logic             matchFlag_reg;
    logic             wrapFlag_reg;
    logic             matchIrqEnable_reg;
    logic             wrapIrqEnable_reg;
    logic             ocState_reg;
    logic             matchPend_reg;
    logic [7:0]       busRdata_reg;
    logic             matchIrq_reg;
    logic             wrapIrq_reg;
    logic             bottom_reg;

    logic             tickNow;
    logic             isPwm;
    logic             atTop;
    logic             atMax;
    logic             atBottom;
    logic             rawMatch;
    logic             realMatch;
    logic             forceHit;
    logic             wrapEvent;
    logic [CNT_W-1:0] count_next;
    logic             ocState_next;
    logic             wrCtl;
    logic             wrCount;
    logic             wrMatch;
    logic             wrFlag;
    logic             wrMask;
    logic             wrAsync;

    tmc_tick_if tickBus ();

    // Reset release through two flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    // Crystal pin: two-flop sync, then edge from stages two and three
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            xtalSync_reg <= 3'h0;
        end else begin
            xtalSync_reg <= {xtalSync_reg[1:0], crystalPinOne};
        end
    end

    assign tickBus.clockSelect = clockSelect_reg;
    assign tickBus.asyncSelect = asyncSel_reg;
    assign tickBus.crystalTick = xtalSync_reg[1] & ~xtalSync_reg[2];

    tmc_tick_gen u_tick (
        .mclk (mclk),
        .rstN (rstN),
        .tick (tickBus.gen)
    );
    assign tickNow = tickBus.timerTick;

    assign wrCtl   = busWrite && busAddr == IDX_TIMER_CONTROL;
    assign wrCount = busWrite && busAddr == IDX_COUNT_VALUE;
    assign wrMatch = busWrite && busAddr == IDX_MATCH_VALUE;
    assign wrFlag  = busWrite && busAddr == IDX_IRQ_FLAG;
    assign wrMask  = busWrite && busAddr == IDX_IRQ_MASK;
    assign wrAsync = busWrite && busAddr == IDX_ASYNC_STATUS;

    assign isPwm = wgm_reg == TMC_WGM_PCPWM || wgm_reg == TMC_WGM_FAST;
    assign atMax = countValue_reg == MAX_VAL;
    assign atBottom = countValue_reg == BOTTOM_VAL;
    assign atTop = (wgm_reg == TMC_WGM_CTC) ? (countValue_reg == matchValue_reg) : atMax;
    assign rawMatch = countValue_reg == matchValue_reg;
    assign realMatch = tickNow && rawMatch && !block_reg;
    assign forceHit = wrCtl && busWdata[CTL_FORCE_BIT] && !isPwm;

    // Control fields; force bit is a strobe, never stored
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            clockSelect_reg <= CTL_RESET[2:0];
            wgm_reg         <= TMC_WGM_NORMAL;
            com_reg         <= TMC_COM_OFF;
        end else if (wrCtl) begin
            clockSelect_reg <= busWdata[CTL_CS_LSB +: 3];
            wgm_reg         <= tmc_wgm_t'({busWdata[CTL_WGM1_BIT], busWdata[CTL_WGM0_BIT]});
            com_reg         <= tmc_com_t'(busWdata[CTL_COM_LSB +: 2]);
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            asyncSel_reg <= 1'b0;
        end else if (wrAsync) begin
            asyncSel_reg <= busWdata[ASYNC_SEL_BIT];
        end
    end

    always_comb begin
        count_next = countValue_reg;
        unique case (wgm_reg)
            TMC_WGM_NORMAL: count_next = countValue_reg + CNT_W'(1);
            TMC_WGM_CTC: count_next = rawMatch ? BOTTOM_VAL : countValue_reg + CNT_W'(1);
            TMC_WGM_FAST: count_next = atMax ? BOTTOM_VAL : countValue_reg + CNT_W'(1);
            TMC_WGM_PCPWM: begin
                if (dirDown_reg) begin
                    count_next = atBottom ? countValue_reg + CNT_W'(1)
                                          : countValue_reg - CNT_W'(1);
                end else begin
                    count_next = atMax ? countValue_reg - CNT_W'(1)
                                       : countValue_reg + CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            countValue_reg <= COUNT_RESET;
        end else if (wrCount) begin
            // CPU write wins, regardless of ticks
            countValue_reg <= busWdata;
        end else if (tickNow) begin
            countValue_reg <= count_next;
        end
    end

    // Count direction for the dual-slope mode
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dirDown_reg <= 1'b0;
        end else if (wgm_reg != TMC_WGM_PCPWM) begin
            dirDown_reg <= 1'b0;
        end else if (tickNow) begin
            dirDown_reg <= dirDown_reg ? !atBottom : atMax;
        end
    end

    // block held until the next tick, even while stopped
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            block_reg <= 1'b0;
        end else if (wrCount) begin
            block_reg <= 1'b1;
        end else if (tickNow) begin
            block_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchBuf_reg <= MATCH_RESET;
        end else if (wrMatch) begin
            matchBuf_reg <= busWdata;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchValue_reg <= MATCH_RESET;
        end else if (!isPwm) begin
            if (wrMatch) begin
                matchValue_reg <= busWdata;
            end
        end else if (tickNow && ((wgm_reg == TMC_WGM_FAST && atMax) ||
                                 (wgm_reg == TMC_WGM_PCPWM && atMax && !dirDown_reg))) begin
            matchValue_reg <= matchBuf_reg;
        end
    end

    // Match pipelined one tick so the flag lands a tick later
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchPend_reg <= 1'b0;
        end else if (tickNow) begin
            matchPend_reg <= realMatch;
        end
    end

    // match flag; set wins over clear
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchFlag_reg <= 1'b0;
        end else if (tickNow && matchPend_reg) begin
            matchFlag_reg <= 1'b1;
        end else if ((wrFlag && busWdata[MATCH_BIT]) || matchIrqAck) begin
            matchFlag_reg <= 1'b0;
        end
    end

    always_comb begin
        wrapEvent = 1'b0;
        if (tickNow && !wrCount) begin
            unique case (wgm_reg)
                TMC_WGM_NORMAL: wrapEvent = atMax;
                TMC_WGM_CTC:    wrapEvent = atMax && !rawMatch;
                TMC_WGM_FAST:   wrapEvent = atMax;
                TMC_WGM_PCPWM:  wrapEvent = atBottom && dirDown_reg;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wrapFlag_reg <= 1'b0;
        end else if (wrapEvent) begin
            wrapFlag_reg <= 1'b1;
        end else if ((wrFlag && busWdata[WRAP_BIT]) || wrapIrqAck) begin
            wrapFlag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchIrqEnable_reg <= 1'b0;
            wrapIrqEnable_reg  <= 1'b0;
        end else if (wrMask) begin
            matchIrqEnable_reg <= busWdata[MATCH_BIT];
            wrapIrqEnable_reg  <= busWdata[WRAP_BIT];
        end
    end

    function automatic logic comAction(input tmc_com_t mode, input logic cur);
        comAction = cur;
        unique case (mode)
            TMC_COM_OFF:    comAction = cur;
            TMC_COM_TOGGLE: comAction = !cur;
            TMC_COM_CLEAR:  comAction = 1'b0;
            TMC_COM_SET:    comAction = 1'b1;
        endcase
    endfunction : comAction

    // Output state: no action when off, kept across modes
    always_comb begin
        ocState_next = ocState_reg;
        if (forceHit) begin
            // force acts with the output mode being written
            ocState_next = comAction(tmc_com_t'(busWdata[CTL_COM_LSB +: 2]), ocState_reg);
        end else if (realMatch && !isPwm) begin
            ocState_next = comAction(com_reg, ocState_reg);
        end else if (isPwm && tickNow && com_reg[1]) begin
            if (realMatch) begin
                ocState_next = (wgm_reg == TMC_WGM_PCPWM) ? (com_reg[0] ^ dirDown_reg) : com_reg[0];
            end else if (wgm_reg == TMC_WGM_FAST && atMax) begin
                ocState_next = !com_reg[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ocState_reg <= 1'b0;
        end else begin
            ocState_reg <= ocState_next;
        end
    end

    // Read mux: buffer seen in PWM modes, force bit reads zero
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            busRdata_reg <= 8'h00;
        end else if (busRead) begin
            unique case (busAddr)
                IDX_TIMER_CONTROL: busRdata_reg <= {1'b0, wgm_reg[1], com_reg, wgm_reg[0],
                                                    clockSelect_reg};
                IDX_COUNT_VALUE:   busRdata_reg <= countValue_reg;
                IDX_MATCH_VALUE:   busRdata_reg <= isPwm ? matchBuf_reg : matchValue_reg;
                IDX_IRQ_FLAG:      busRdata_reg <= {6'h00, matchFlag_reg, wrapFlag_reg};
                IDX_IRQ_MASK:      busRdata_reg <= {6'h00, matchIrqEnable_reg, wrapIrqEnable_reg};
                IDX_ASYNC_STATUS:  busRdata_reg <= {4'h0, asyncSel_reg, 3'h0};
                default:           busRdata_reg <= 8'h00;
            endcase
        end else begin
            busRdata_reg <= 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            matchIrq_reg <= 1'b0;
            wrapIrq_reg  <= 1'b0;
            bottom_reg   <= 1'b0;
        end else begin
            matchIrq_reg <= matchFlag_reg && matchIrqEnable_reg;
            wrapIrq_reg  <= wrapFlag_reg && wrapIrqEnable_reg;
            bottom_reg   <= atBottom;
        end
    end

    assign busRdata    = busRdata_reg;
    assign matchIrq    = matchIrq_reg;
    assign wrapIrq     = wrapIrq_reg;
    assign matchOutput = ocState_reg;
    assign bottomFlag  = bottom_reg;
endmodule : timer8_counter_compare
`default_nettype wire

// ---- sim/tmc_checker_sva.sv ----
/*
 * Port checker of the 8-bit counter/compare timer: CPU port answers and
 * interrupt gating. Bound to timer8_counter_compare, sees its ports only.
 */
`timescale 1ns/10ps
`default_nettype none
module tmc_checker_sva
    import tmc_pkg::*;
#(
    parameter int unsigned ADDR_W = 3
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [7:0]        busWdata,
    input wire logic              busWrite,
    input wire logic              busRead,
    input wire logic [7:0]        busRdata,
    input wire logic              matchIrq,
    input wire logic              wrapIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (!$past(busRead) |-> busRdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (
        $past(busRead) && $past(busAddr) > IDX_ASYNC_STATUS |-> busRdata == 8'h00)
        else $error("unmapped index read not zero");
    a_count_wr_rd: assert property (
        busWrite && busAddr == IDX_COUNT_VALUE ##1 busRead && busAddr == IDX_COUNT_VALUE
        |=> busRdata == $past(busWdata, 2))
        else $error("counter write not seen by the next read");
    a_match_wr_rd: assert property (
        busWrite && busAddr == IDX_MATCH_VALUE ##1 busRead && busAddr == IDX_MATCH_VALUE
        |=> busRdata == $past(busWdata, 2))
        else $error("compare value write not seen by the next read");
    a_mask_wr_rd: assert property (
        busWrite && busAddr == IDX_IRQ_MASK ##1 busRead && busAddr == IDX_IRQ_MASK
        |=> busRdata[1:0] == $past(busWdata[1:0], 2))
        else $error("mask write not seen by the next read");
    a_ctl_force_zero: assert property (
        busWrite && busAddr == IDX_TIMER_CONTROL ##1 busRead && busAddr == IDX_TIMER_CONTROL
        |=> busRdata == {1'b0, $past(busWdata[6:0], 2)})
        else $error("control readback wrong or force bit not zero");
    a_match_irq_gate: assert property (
        $past(busRead) && $past(busAddr) == IDX_IRQ_FLAG && !busRdata[MATCH_BIT]
        |-> !matchIrq)
        else $error("match request without match flag");
    a_wrap_irq_gate: assert property (
        $past(busRead) && $past(busAddr) == IDX_IRQ_FLAG && !busRdata[WRAP_BIT]
        |-> !wrapIrq)
        else $error("wrap request without wrap flag");
endmodule : tmc_checker_sva
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 * Self-checking bench of the 8-bit counter/compare timer.
 * Assumes the design's CPU port answers reads one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tmc_pkg::*;
    logic       mclk;
    logic       nrst;
    logic [2:0] busAddr;
    logic [7:0] busWdata;
    logic       busWrite;
    logic       busRead;
    logic [7:0] busRdata;
    logic       crystalPinOne;
    logic       matchIrqAck;
    logic       wrapIrqAck;
    logic       matchIrq;
    logic       wrapIrq;
    logic       matchOutput;
    logic       bottomFlag;
    int         errCount;
    int         testsRun;
    logic [7:0] d;
    logic [7:0] c1;
    logic [7:0] mv;
    logic       outExp;
    logic [1:0] com;
    int         divTab [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

    timer8_counter_compare timer8_counter_compare_inst (.mclk(mclk), .nrst(nrst),
        .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
        .busRdata(busRdata), .crystalPinOne(crystalPinOne), .matchIrqAck(matchIrqAck),
        .wrapIrqAck(wrapIrqAck), .matchIrq(matchIrq), .wrapIrq(wrapIrq),
        .matchOutput(matchOutput), .bottomFlag(bottomFlag));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reportAndStop();
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : reportAndStop

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        busAddr  <= a;
        busWdata <= v;
        busWrite <= 1'b1;
        @(posedge mclk);
        busWrite <= 1'b0;
        #1;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge mclk);
        busRead <= 1'b0;
        #1;
        v = busRdata;
    endtask : rd

    // Read spacing is two ticks of the selected divider
    function automatic logic [7:0] expSpan(input logic [7:0] c, input int cs);
        expSpan = (cs == 0) ? c : c + 8'h02;
    endfunction : expSpan

    function automatic logic fexp(input logic [1:0] m, input logic old);
        case (m)
            2'h1: fexp = ~old;
            2'h2: fexp = 1'b0;
            2'h3: fexp = 1'b1;
            default: fexp = old;
        endcase
    endfunction : fexp

    initial begin
        repeat (40000) @(posedge mclk);
        errCount++;
        reportAndStop();
    end

    initial begin
        nrst = 1'b0;
        busAddr = 3'h0;
        busWdata = 8'h00;
        busWrite = 1'b0;
        busRead = 1'b0;
        crystalPinOne = 1'b0;
        matchIrqAck = 1'b0;
        wrapIrqAck = 1'b0;
        errCount = 0;
        testsRun = 0;
        void'($urandom(11));
        cyc(6);
        check("reset_outputs", {4'h0, matchIrq, wrapIrq, matchOutput, bottomFlag}, 8'h00);
        nrst <= 1'b1;
        cyc(3);
        for (int i = 0; i < 8; i++) begin
            mv = (i == 0) ? 8'hFF : 8'($urandom);
            wr(IDX_COUNT_VALUE, mv);
            rd(IDX_COUNT_VALUE, d);
            check("count_rw", d, mv);
        end
        rd(3'h6, d);
        check("unmapped", d, 8'h00);
        wr(IDX_COUNT_VALUE, 8'h00);
        cyc(3);
        check("bottom_set", {7'h0, bottomFlag}, 8'h01);
        wr(IDX_COUNT_VALUE, 8'h01);
        cyc(3);
        check("bottom_clr", {7'h0, bottomFlag}, 8'h00);
        wr(IDX_IRQ_MASK, 8'h03);
        rd(IDX_IRQ_MASK, d);
        check("mask_rw", d, 8'h03);
        for (int cs = 0; cs < 8; cs++) begin
            wr(IDX_TIMER_CONTROL, 8'(cs));
            cyc(3);
            rd(IDX_COUNT_VALUE, c1);
            cyc(2 * divTab[cs] - 1);
            rd(IDX_COUNT_VALUE, d);
            check("tick_span", d, expSpan(c1, cs));
        end
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_ASYNC_STATUS, 8'h08);
        wr(IDX_TIMER_CONTROL, 8'h01);
        cyc(4);
        rd(IDX_COUNT_VALUE, c1);
        repeat (10) begin
            crystalPinOne <= 1'b1;
            cyc(4);
            crystalPinOne <= 1'b0;
            cyc(4);
        end
        cyc(4);
        rd(IDX_COUNT_VALUE, d);
        check("crystal_ticks", d, c1 + 8'h0A);
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_ASYNC_STATUS, 8'h00);
        wr(IDX_MATCH_VALUE, 8'h40);
        wr(IDX_COUNT_VALUE, 8'hF8);
        // One tick flushes a match still pending from earlier runs
        wr(IDX_TIMER_CONTROL, 8'h01);
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_IRQ_FLAG, 8'h03);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_TIMER_CONTROL, 8'h01);
        cyc(20);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_IRQ_FLAG, d);
        check("wrap_flag", {6'h00, d[1:0]}, 8'h01);
        check("wrap_irq", {7'h0, wrapIrq}, 8'h01);
        wr(IDX_IRQ_FLAG, 8'h01);
        rd(IDX_IRQ_FLAG, d);
        cyc(2);
        check("wrap_w1c", {6'h00, d[WRAP_BIT], wrapIrq}, 8'h00);
        // Written count equal to compare value must not match
        wr(IDX_COUNT_VALUE, 8'h40);
        wr(IDX_IRQ_MASK, 8'h02);
        wr(IDX_TIMER_CONTROL, 8'h01);
        cyc(20);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_IRQ_FLAG, d);
        check("match_blocked", {7'h0, d[MATCH_BIT]}, 8'h00);
        // count written apart from the compare value
        wr(IDX_COUNT_VALUE, 8'h3C);
        wr(IDX_TIMER_CONTROL, 8'h01);
        cyc(20);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_IRQ_FLAG, d);
        check("match_flag", {6'h00, d[1:0]}, 8'h02);
        check("match_irq", {7'h0, matchIrq}, 8'h01);
        matchIrqAck <= 1'b1;
        @(posedge mclk);
        matchIrqAck <= 1'b0;
        cyc(3);
        rd(IDX_IRQ_FLAG, d);
        check("match_ack", {6'h00, d[MATCH_BIT], matchIrq}, 8'h00);
        wr(IDX_COUNT_VALUE, 8'h00);
        mv = 8'($urandom_range(40, 2));
        wr(IDX_MATCH_VALUE, mv);
        wr(IDX_TIMER_CONTROL, 8'h41);
        repeat (20) begin
            cyc($urandom_range(9, 1));
            rd(IDX_COUNT_VALUE, d);
            check("ctc_top", {7'h0, d <= mv}, 8'h01);
        end
        wr(IDX_TIMER_CONTROL, 8'h00);
        rd(IDX_IRQ_FLAG, d);
        check("ctc_no_wrap", {7'h0, d[WRAP_BIT]}, 8'h00);
        wr(IDX_IRQ_FLAG, 8'h03);
        wr(IDX_COUNT_VALUE, 8'h33);
        outExp = 1'b0;
        // output state set by force in normal mode first
        for (int i = 0; i < 10; i++) begin
            com = (i == 0) ? 2'h3 : 2'($urandom);
            wr(IDX_TIMER_CONTROL, {2'h2, com, 4'h0});
            rd(IDX_TIMER_CONTROL, d);
            cyc(1);
            outExp = fexp(com, outExp);
            check("force_out", {7'h0, matchOutput}, {7'h0, outExp});
        end
        rd(IDX_IRQ_FLAG, d);
        check("force_no_flag", {7'h0, d[MATCH_BIT]}, 8'h00);
        rd(IDX_COUNT_VALUE, d);
        check("force_no_clear", d, 8'h33);
        wr(IDX_TIMER_CONTROL, 8'h48);
        cyc(3);
        check("mode_keep_out", {7'h0, matchOutput}, {7'h0, outExp});
        mv = 8'($urandom);
        wr(IDX_MATCH_VALUE, mv);
        rd(IDX_MATCH_VALUE, d);
        check("pwm_buffer_rw", d, mv);
        reportAndStop();
    end
endmodule : testbench

bind timer8_counter_compare tmc_checker_sva #(.ADDR_W(ADDR_W)) tmc_checker_sva_inst (
    .mclk(mclk), .nrst(nrst), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
    .matchIrq(matchIrq), .wrapIrq(wrapIrq));
`default_nettype wire
